// *** core/spi_tunnel_pkg.sv ***
// Shared constants and types for the serial-link SPI tunnel.
package spi_tunnel_pkg;

    // Register offsets on the local configuration port.
    localparam logic [7:0] BC_CTRL_OFFSET = 8'h23;
    localparam logic [7:0] SIDEBAND_CTRL_OFFSET = 8'h43;
    localparam logic [7:0] TUNNEL_STATUS_OFFSET = 8'h7e;

    // Values after reset.
    localparam logic [7:0] BC_CTRL_RESET = 8'h00;
    localparam logic [7:0] SIDEBAND_CTRL_RESET = 8'h00;

    // Field positions.
    localparam int BC_DIV2_BIT = 6;
    localparam int BC_FAST_BIT = 4;
    localparam int MODE_LSB = 0;
    localparam int MODE_MSB = 2;
    localparam int STAT_FWD_BIT = 0;
    localparam int STAT_REV_BIT = 1;
    localparam int STAT_SS_BIT = 2;
    localparam int STAT_EMPTY_BIT = 3;
    localparam int STAT_OVF_BIT = 4;
    localparam int STAT_LANES_BIT = 5;

    // Mode codes of the sideband mode select field.
    localparam logic [2:0] MODE_SPI_FORWARD = 3'h6;
    localparam logic [2:0] MODE_SPI_REVERSE = 3'h7;

    // Back-channel frame periods in nanoseconds and the clock period.
    localparam int CLK_PERIOD_NS = 10;
    localparam int BC_FRAME_NS_5M = 7500;
    localparam int BC_FRAME_NS_10M = 3750;
    localparam int BC_FRAME_NS_20M = 1875;

    // Frame periods in clock cycles, rounded down.
    localparam int FRAME_CYC_5M = BC_FRAME_NS_5M / CLK_PERIOD_NS;
    localparam int FRAME_CYC_10M = BC_FRAME_NS_10M / CLK_PERIOD_NS;
    localparam int FRAME_CYC_20M = BC_FRAME_NS_20M / CLK_PERIOD_NS;
    localparam int FRAME_CNT_W = 10;

    // Tunnel bits carried by one forward frame.
    typedef struct packed {
        logic valid;
        logic sclk;
        logic mosi;
        logic ss_n;
    } fwd_frame_t;

    // Tunnel bits placed in one back-channel frame.
    typedef struct packed {
        logic strobe;
        logic ss_n;
        logic data_valid;
        logic data;
    } bc_frame_t;

    // Back-channel rate choices.
    typedef enum logic [1:0] {
        RATE_5M,
        RATE_10M,
        RATE_20M
    } bc_rate_t;

endpackage

// *** core/bit_sync.sv ***
// Two-stage synchroniser for a group of level signals.
`timescale 1ns/1ns
`default_nettype none
module bit_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    // First stage; only the second stage reads it.
    logic [WIDTH-1:0] meta_q;

    // Both stages load the reset value while rst is high.
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= INIT;
            q <= INIT;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end

endmodule
`default_nettype wire

// *** core/sample_ram.sv ***
// Small sample memory with a registered read port.
`timescale 1ns/1ns
`default_nettype none
module sample_ram #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 16,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);

    // Storage array.
    logic [WIDTH-1:0] mem [DEPTH];

    // Write on request; read data is always registered.
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end

endmodule
`default_nettype wire

// *** core/spi_tunnel.sv ***
// SPI tunnel over the secondary lane of the serial link, receiving end.
// Function
// - Mode codes 110 forward, 111 reverse.
// - Tunnel works only with two lanes.
// - Forward follows video; reverse opposes it.
// - Tunnel never reaches configuration registers.
// - Rebuild clock, data, select from frames.
// - Hold rebuilt data while clock high.
// - Rebuilt clock lags data one pixel clock.
// - Reverse: synchronise select, clock; capture data.
// - Buffer samples; each frame carries select.
// - At most one sample per frame.
// - Frame rate from divider or fast enable.
`timescale 1ns/1ns
`default_nettype none
module spi_tunnel
    import spi_tunnel_pkg::*;
#(
    parameter int DEPTH = 16
) (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic PIXEL_CLK,
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    input wire logic DUAL_LANE,
    input wire fwd_frame_t FWD_FRAME,
    output logic FWD_SCLK,
    output logic FWD_MOSI,
    output logic FWD_SS_N,
    input wire logic REV_SCLK,
    input wire logic REV_MOSI,
    input wire logic REV_SS_N,
    output bc_frame_t BC_FRAME
);

    localparam int AW = $clog2(DEPTH);

    // Rate decode, used for the frame timer only.
    function automatic bc_rate_t rate_of(input logic [7:0] ctrl);
        if (ctrl[BC_FAST_BIT]) begin
            rate_of = RATE_20M;
        end else if (ctrl[BC_DIV2_BIT]) begin
            rate_of = RATE_10M;
        end else begin
            rate_of = RATE_5M;
        end
    endfunction

    // ------------------------------------------------------------
    // Register file on the oscillator clock.
    // ------------------------------------------------------------

    logic [7:0] sideband_channel_control_q; // Tunnel mode register.
    logic [7:0] bc_ctrl_q; // Back-channel rate register.
    logic [7:0] rdata_q; // Registered read data.
    logic ovf_q; // Sticky buffer overflow.
    logic ovf_d; // Next overflow value.
    logic [7:0] status_w; // Live status view.
    logic [2:0] sideband_mode_select; // Mode field.
    logic lanes_ok; // Synchronised two-lane indication.
    logic fwd_mode; // Forward tunnel enabled.
    logic rev_mode; // Reverse tunnel enabled.
    logic wr_side; // Write to the mode register.
    logic wr_bc; // Write to the rate register.
    logic wr_stat; // Write to the status register.
    logic [7:0] rdata_d; // Read mux result.

    // Address decode for the three registers.
    assign wr_side = REG_WR && (REG_ADDR == SIDEBAND_CTRL_OFFSET);
    assign wr_bc = REG_WR && (REG_ADDR == BC_CTRL_OFFSET);
    assign wr_stat = REG_WR && (REG_ADDR == TUNNEL_STATUS_OFFSET);

    // Mode select; the tunnel needs the secondary lane.
    assign sideband_mode_select =
        sideband_channel_control_q[MODE_MSB:MODE_LSB];
    assign fwd_mode = lanes_ok &&
        (sideband_mode_select == MODE_SPI_FORWARD);
    assign rev_mode = lanes_ok &&
        (sideband_mode_select == MODE_SPI_REVERSE);

    // Read data selection; unmapped offsets read as zero.
    always_comb begin
        case (REG_ADDR)
            SIDEBAND_CTRL_OFFSET: rdata_d = sideband_channel_control_q;
            BC_CTRL_OFFSET: rdata_d = bc_ctrl_q;
            TUNNEL_STATUS_OFFSET: rdata_d = status_w;
            default: rdata_d = 8'h00;
        endcase
    end

    // Register writes and the read data register.
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            sideband_channel_control_q <= SIDEBAND_CTRL_RESET;
            bc_ctrl_q <= BC_CTRL_RESET;
            rdata_q <= 8'h00;
        end else begin
            if (wr_side) begin
                sideband_channel_control_q <= REG_WDATA;
            end
            if (wr_bc) begin
                bc_ctrl_q <= REG_WDATA;
            end
            if (REG_RD) begin
                rdata_q <= rdata_d;
            end
        end
    end

    assign REG_RDATA = rdata_q;

    // ------------------------------------------------------------
    // Reverse tunnel on the oscillator clock.
    // ------------------------------------------------------------

    logic [3:0] pins_s; // Synchronised pins and lane state.
    logic rsclk_s; // Synchronised reverse clock.
    logic rmosi_s; // Synchronised reverse data.
    logic rss_n_s; // Synchronised reverse select.
    logic rsclk_prev_q; // Previous reverse clock level.
    logic edge_w; // Active clock edge seen.
    logic [AW:0] count_q; // Samples held in the buffer.
    logic [AW:0] count_d; // Next sample count.
    logic [AW-1:0] wr_ptr_q; // Buffer write index.
    logic [AW-1:0] rd_ptr_q; // Buffer read index.
    logic avail_q; // Buffer head is readable.
    logic push_w; // Store one sample.
    logic pop_w; // Send one sample.
    logic full_w; // Buffer full.
    logic head_w; // Sample at the buffer head.
    logic [FRAME_CNT_W-1:0] frame_cnt_q; // Frame timer.
    logic [FRAME_CNT_W-1:0] frame_len_w; // Frame period minus one.
    logic tick_w; // Frame boundary.
    bc_frame_t bc_q; // Outgoing frame bits.

    // Pins come from outside; two stages before any logic; select idles high.
    bit_sync #(.WIDTH(4), .INIT(4'h4)) pin_sync (
        .clk(CLOCK),
        .rst(SYS_RST),
        .d({REV_SCLK, REV_SS_N, REV_MOSI, DUAL_LANE}),
        .q(pins_s)
    );

    // Split of the synchronised group.
    assign rsclk_s = pins_s[3];
    assign rss_n_s = pins_s[2];
    assign rmosi_s = pins_s[1];
    assign lanes_ok = pins_s[0];

    // Rising clock edge inside an active select takes data.
    assign edge_w = rsclk_s && !rsclk_prev_q && !rss_n_s;
    assign full_w = (count_q == (AW+1)'(DEPTH));
    assign push_w = rev_mode && edge_w && !full_w;
    assign pop_w = rev_mode && tick_w && avail_q;
    assign count_d = count_q + (AW+1)'(push_w) - (AW+1)'(pop_w);

    // Frame period chosen by divider or fast enable.
    always_comb begin
        case (rate_of(bc_ctrl_q))
            RATE_20M: frame_len_w = FRAME_CNT_W'(FRAME_CYC_20M - 1);
            RATE_10M: frame_len_w = FRAME_CNT_W'(FRAME_CYC_10M - 1);
            default: frame_len_w = FRAME_CNT_W'(FRAME_CYC_5M - 1);
        endcase
    end

    assign tick_w = (frame_cnt_q == frame_len_w);

    // Overflow is set by a lost sample; writing one clears it.
    assign ovf_d = (rev_mode && edge_w && full_w) ||
        (ovf_q && !(wr_stat && REG_WDATA[STAT_OVF_BIT]));

    // Samples wait here for their frame.
    sample_ram #(.WIDTH(1), .DEPTH(DEPTH)) sample_buf (
        .clk(CLOCK),
        .wr_en(push_w),
        .wr_addr(wr_ptr_q),
        .wr_data(rmosi_s),
        .rd_addr(rd_ptr_q),
        .rd_data(head_w)
    );

    // Edge history, frame timer and overflow flag.
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            rsclk_prev_q <= 1'b0;
            frame_cnt_q <= '0;
            ovf_q <= 1'b0;
        end else begin
            rsclk_prev_q <= rsclk_s;
            frame_cnt_q <= (tick_w || !rev_mode) ? '0 : frame_cnt_q + 1'b1;
            ovf_q <= ovf_d;
        end
    end

    // Buffer pointers; leaving reverse mode empties the buffer.
    always_ff @(posedge CLOCK) begin
        if (SYS_RST || !rev_mode) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            avail_q <= 1'b0;
        end else begin
            if (push_w) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop_w) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            count_q <= count_d;
            // Lags the count so the head read has settled.
            avail_q <= (count_q != '0) && !pop_w;
        end
    end

    // One frame per tick: select state always, one sample at most.
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            bc_q <= '{strobe: 1'b0, ss_n: 1'b1, data_valid: 1'b0, data: 1'b0};
        end else begin
            bc_q.strobe <= rev_mode && tick_w;
            bc_q.ss_n <= rev_mode ? rss_n_s : 1'b1;
            bc_q.data_valid <= pop_w;
            bc_q.data <= pop_w ? head_w : bc_q.data;
        end
    end

    assign BC_FRAME = bc_q;

    // Status view; tunnel data never enters the register file.
    assign status_w = {2'b00, lanes_ok, ovf_q, (count_q == '0),
        rss_n_s, rev_mode, fwd_mode};

    // ------------------------------------------------------------
    // Forward tunnel on the recovered pixel clock.
    // ------------------------------------------------------------

    logic [1:0] px_s; // Synchronised reset and forward enable.
    logic px_rst; // Pixel-domain reset.
    logic px_fwd; // Pixel-domain forward enable.
    logic smp_sclk_q; // Sampled frame clock bit.
    logic smp_mosi_q; // Sampled frame data bit.
    logic smp_ss_n_q; // Sampled frame select bit.
    logic sclk_q; // Rebuilt clock, one stage later.
    logic sclk_dly_q; // Clock sample held one extra stage.
    logic fwd_cross_q; // Forward enable as a register, safe to cross.
    logic mosi_q; // Rebuilt data.
    logic ss_n_q; // Rebuilt select.

    // Only a flop may feed the crossing; the mode decode could glitch.
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            fwd_cross_q <= 1'b0;
        end else begin
            fwd_cross_q <= fwd_mode;
        end
    end

    // Reset and mode cross into the pixel domain as levels.
    bit_sync #(.WIDTH(2), .INIT(2'h2)) px_sync (
        .clk(PIXEL_CLK),
        .rst(1'b0),
        .d({SYS_RST, fwd_cross_q}),
        .q(px_s)
    );

    assign px_rst = px_s[1];
    assign px_fwd = px_s[0];

    // Take the tunnel bits of each valid frame.
    always_ff @(posedge PIXEL_CLK) begin
        if (px_rst || !px_fwd) begin
            smp_sclk_q <= 1'b0;
            smp_mosi_q <= 1'b0;
            smp_ss_n_q <= 1'b1;
        end else if (FWD_FRAME.valid) begin
            smp_sclk_q <= FWD_FRAME.sclk;
            smp_mosi_q <= FWD_FRAME.mosi;
            smp_ss_n_q <= FWD_FRAME.ss_n;
        end
    end

    // Rebuild the outputs; idle keeps select high and lines still.
    always_ff @(posedge PIXEL_CLK) begin
        if (px_rst) begin
            sclk_dly_q <= 1'b0;
            sclk_q <= 1'b0;
            mosi_q <= 1'b0;
            ss_n_q <= 1'b1;
        end else if (!px_fwd) begin
            sclk_dly_q <= 1'b0;
            sclk_q <= 1'b0;
            ss_n_q <= 1'b1;
        end else begin
            // Clock goes out one pixel clock after its data.
            sclk_dly_q <= smp_sclk_q;
            sclk_q <= sclk_dly_q;
            ss_n_q <= smp_ss_n_q;
            // Data stays put while the rebuilt clock is high.
            if (!sclk_q) begin
                mosi_q <= smp_mosi_q;
            end
        end
    end

    assign FWD_SCLK = sclk_q;
    assign FWD_MOSI = mosi_q;
    assign FWD_SS_N = ss_n_q;

endmodule
`default_nettype wire

// *** tb/spi_tunnel_sva.sv ***
// Port-level checks of the SPI tunnel and its bind.
`timescale 1ns/1ns
`default_nettype none
module spi_tunnel_sva
    import spi_tunnel_pkg::*;
#(
    parameter int DEPTH = 16
) (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic PIXEL_CLK,
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_WDATA,
    input wire logic [7:0] REG_RDATA,
    input wire logic DUAL_LANE,
    input wire fwd_frame_t FWD_FRAME,
    input wire logic FWD_SCLK,
    input wire logic FWD_MOSI,
    input wire logic FWD_SS_N,
    input wire logic REV_SCLK,
    input wire logic REV_MOSI,
    input wire logic REV_SS_N,
    input wire bc_frame_t BC_FRAME
);
    // Cycles since the last frame strobe, saturating.
    logic [11:0] gap_q;
    always_ff @(posedge CLOCK) begin
        if (SYS_RST || BC_FRAME.strobe) begin
            gap_q <= '0;
        end else if (gap_q != 12'hfff) begin
            gap_q <= gap_q + 12'h001;
        end
    end
    mosi_hold_a: assert property (@(posedge PIXEL_CLK)
        disable iff (SYS_RST)
        FWD_SCLK && $past(FWD_SCLK) |-> $stable(FWD_MOSI))
        else $error("rebuilt data moved while clock high");
    sclk_lag_a: assert property (@(posedge PIXEL_CLK)
        disable iff (SYS_RST)
        $rose(FWD_SCLK) |-> $past(FWD_FRAME.sclk, 3))
        else $error("rebuilt clock not three edges after its frame");
    mosi_rebuild_a: assert property (@(posedge PIXEL_CLK)
        disable iff (SYS_RST)
        FWD_MOSI != $past(FWD_MOSI) |-> FWD_MOSI == $past(FWD_FRAME.mosi, 2))
        else $error("rebuilt data differs from frame");
    ss_rebuild_a: assert property (@(posedge PIXEL_CLK)
        disable iff (SYS_RST)
        FWD_SS_N != $past(FWD_SS_N) |-> FWD_SS_N == $past(FWD_FRAME.ss_n, 2))
        else $error("rebuilt select differs from frame");
    fwd_reset_a: assert property (@(posedge PIXEL_CLK)
        SYS_RST [*3] |=> FWD_SS_N && !FWD_SCLK)
        else $error("rebuilt outputs not idle in reset");
    bc_reset_a: assert property (@(posedge CLOCK)
        SYS_RST |=> !BC_FRAME.strobe && BC_FRAME.ss_n && REG_RDATA == 8'h00)
        else $error("outputs not idle in reset");
    rdata_hold_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        !$past(REG_RD) |-> $stable(REG_RDATA))
        else $error("read data moved without a read");
    data_strobe_a: assert property (@(posedge CLOCK)
        disable iff (SYS_RST)
        BC_FRAME.data_valid |-> BC_FRAME.strobe)
        else $error("data valid outside a frame");
    strobe_pulse_a: assert property (@(posedge CLOCK)
        disable iff (SYS_RST)
        BC_FRAME.strobe |=> !BC_FRAME.strobe [*8])
        else $error("frame strobe too long");
    frame_gap_a: assert property (@(posedge CLOCK)
        disable iff (SYS_RST)
        BC_FRAME.strobe |-> gap_q >= FRAME_CYC_20M - 1)
        else $error("frames closer than the fastest period");
endmodule
bind spi_tunnel spi_tunnel_sva #(.DEPTH(DEPTH)) chk (.CLOCK(CLOCK),
    .SYS_RST(SYS_RST), .PIXEL_CLK(PIXEL_CLK), .REG_ADDR(REG_ADDR),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA), .DUAL_LANE(DUAL_LANE), .FWD_FRAME(FWD_FRAME),
    .FWD_SCLK(FWD_SCLK), .FWD_MOSI(FWD_MOSI), .FWD_SS_N(FWD_SS_N),
    .REV_SCLK(REV_SCLK), .REV_MOSI(REV_MOSI), .REV_SS_N(REV_SS_N),
    .BC_FRAME(BC_FRAME));
`default_nettype wire

// *** tb/spi_fwd_master.sv ***
// Far-end model: an SPI master whose pins are oversampled into frames.
`timescale 1ns/1ns
`default_nettype none
module spi_fwd_master
    import spi_tunnel_pkg::*;
(
    input wire logic clk,
    output fwd_frame_t frame
);
    // Master pins; the clock stands still low between transfers.
    logic sclk = 1'b0;
    logic mosi = 1'b0;
    logic ss_n = 1'b1;
    fwd_frame_t frame_q = '{1'b0, 1'b0, 1'b0, 1'b1};
    logic [1:0] slot = 2'h0; // Position of the frame in a group of four.
    assign frame = frame_q;
    // Every pixel clock the three pins are sampled into one frame; every
    // fourth frame is marked empty and carries inverted junk.
    always @(posedge clk) begin
        slot <= slot + 2'h1;
        if (slot == 2'h3) begin
            frame_q <= '{1'b0, ~sclk, ~mosi, ~ss_n};
        end else begin
            frame_q <= '{1'b1, sclk, mosi, ss_n};
        end
    end
    // Sends one byte, MSB first, data changing only while the clock is low.
    // A bit lasts eight pixel clocks, well beyond the tunnel's round trip,
    // and the return line is never looked at, as for a write.
    task automatic send(input logic [7:0] b);
        @(posedge clk);
        ss_n <= 1'b0;
        for (int i = 7; i >= 0; i--) begin
            mosi <= b[i];
            repeat (2) @(posedge clk);
            sclk <= 1'b1;
            repeat (4) @(posedge clk);
            sclk <= 1'b0;
            repeat (2) @(posedge clk);
        end
        ss_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// *** tb/spi_tunnel_tb_top.sv ***
// Self-checking testbench of the SPI tunnel.
`timescale 1ns/1ns
`default_nettype none
module spi_tunnel_tb_top;
    import spi_tunnel_pkg::*;
    logic clock = 1'b0;
    logic pixel_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic dual_lane = 1'b1;
    logic rev_sclk = 1'b0;
    logic rev_mosi = 1'b0;
    logic rev_ss_n = 1'b1;
    logic [7:0] reg_rdata;
    fwd_frame_t fwd_frame;
    logic fwd_sclk, fwd_mosi, fwd_ss_n;
    bc_frame_t bc_frame;
    int fails = 0;
    int check_count = 0;
    int cycles = 0;
    int sclk_rises = 0;
    int rev_n = 0;
    int n;
    logic [7:0] fwd_rx = 8'h00;
    logic [3:0] rev_rx = 4'h0;
    logic rev_ss0 = 1'b1;
    logic [3:0] bits = 4'b1011;
    logic [7:0] rate_v [3] = '{8'h00, 8'h40, 8'h50};
    int rate_c [3] = '{FRAME_CYC_5M, FRAME_CYC_10M, FRAME_CYC_20M};
    // Status words expected in the scenarios, built from the field positions.
    localparam logic [7:0] ST_FWD = 8'((1 << STAT_FWD_BIT) |
        (1 << STAT_SS_BIT) | (1 << STAT_EMPTY_BIT) | (1 << STAT_LANES_BIT));
    localparam logic [7:0] ST_OVF = 8'((1 << STAT_REV_BIT) |
        (1 << STAT_OVF_BIT) | (1 << STAT_LANES_BIT));
    localparam logic [7:0] ST_CLR = 8'((1 << STAT_REV_BIT) |
        (1 << STAT_LANES_BIT));
    // The link clock is unrelated in phase to the register clock.
    always #5 clock = ~clock;
    always #24 pixel_clk = ~pixel_clk;
    spi_tunnel uut (.CLOCK(clock), .SYS_RST(sys_rst), .PIXEL_CLK(pixel_clk),
        .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .DUAL_LANE(dual_lane),
        .FWD_FRAME(fwd_frame), .FWD_SCLK(fwd_sclk), .FWD_MOSI(fwd_mosi),
        .FWD_SS_N(fwd_ss_n), .REV_SCLK(rev_sclk), .REV_MOSI(rev_mosi),
        .REV_SS_N(rev_ss_n), .BC_FRAME(bc_frame));
    spi_fwd_master far (.clk(pixel_clk), .frame(fwd_frame));
    // Rebuilt bits are taken on each rising rebuilt clock.
    always @(posedge fwd_sclk) begin
        fwd_rx <= {fwd_rx[6:0], fwd_mosi};
        sclk_rises <= sclk_rises + 1;
    end
    // Collects back-channel data and cuts a hang short.
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (bc_frame.strobe === 1'b1 && bc_frame.data_valid === 1'b1) begin
            rev_rx <= {rev_rx[2:0], bc_frame.data};
            if (rev_n == 0) begin
                rev_ss0 <= bc_frame.ss_n;
            end
            rev_n <= rev_n + 1;
        end
        if (cycles == 60000) begin
            fails++;
            results();
        end
    end
    // Compares a seen value with the expected one.
    task automatic check(input string what, input logic [15:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic reg_write(input logic [7:0] a, d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    // Reads a register and compares; data lands at the edge after the strobe.
    task automatic expect_reg(input string what, input logic [7:0] a, exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 check(what, reg_rdata, exp);
    endtask
    // Counts cycles up to the next frame strobe, bounded.
    task automatic wait_strobe(output int k);
        k = 0;
        do begin
            @(posedge clock);
            #1 k++;
        end while (bc_frame.strobe !== 1'b1 && k < 2000);
    endtask
    initial begin
        repeat (16) @(posedge pixel_clk);
        @(posedge clock);
        sys_rst <= 1'b0;
        expect_reg("mode reset", SIDEBAND_CTRL_OFFSET,
            SIDEBAND_CTRL_RESET);
        expect_reg("rate reset", BC_CTRL_OFFSET, BC_CTRL_RESET);
        reg_write(8'h10, 8'hff);
        expect_reg("unmapped", 8'h10, 8'h00);
        reg_write(SIDEBAND_CTRL_OFFSET, 8'hff);
        expect_reg("mode all bits", SIDEBAND_CTRL_OFFSET, 8'hff);
        reg_write(SIDEBAND_CTRL_OFFSET, 8'h00);
        $display("test registers done");
        far.send(8'h5a);
        check("idle clock", sclk_rises, 0);
        check("idle select", fwd_ss_n, 1'b1);
        dual_lane <= 1'b0;
        reg_write(SIDEBAND_CTRL_OFFSET, {5'h00, MODE_SPI_FORWARD});
        far.send(8'h5a);
        check("one lane clock", sclk_rises, 0);
        dual_lane <= 1'b1;
        repeat (20) @(posedge clock);
        far.send(8'ha5);
        repeat (8) @(posedge pixel_clk);
        check("forward byte", fwd_rx, 8'ha5);
        check("forward edges", sclk_rises, 8);
        check("forward select", fwd_ss_n, 1'b1);
        expect_reg("mode kept", SIDEBAND_CTRL_OFFSET, 8'h06);
        expect_reg("status forward", TUNNEL_STATUS_OFFSET, ST_FWD);
        $display("test forward done");
        for (int i = 0; i < 3; i++) begin
            reg_write(BC_CTRL_OFFSET, rate_v[i]);
            reg_write(SIDEBAND_CTRL_OFFSET, {5'h00, MODE_SPI_REVERSE});
            wait_strobe(n);
            wait_strobe(n);
            check("frame period", n, rate_c[i]);
            reg_write(SIDEBAND_CTRL_OFFSET, 8'h00);
        end
        $display("test rates done");
        reg_write(SIDEBAND_CTRL_OFFSET, {5'h00, MODE_SPI_REVERSE});
        repeat (200) @(posedge clock);
        rev_ss_n <= 1'b0;
        // Thirty cycles a bit: slow enough to wait out the round trip.
        for (int i = 3; i >= 0; i--) begin
            repeat (10) @(posedge clock);
            rev_mosi <= bits[i];
            repeat (10) @(posedge clock);
            rev_sclk <= 1'b1;
            repeat (10) @(posedge clock);
            rev_sclk <= 1'b0;
        end
        for (int k = 0; k < 2000 && rev_n < 4; k++) @(posedge clock);
        check("reverse bits", rev_rx, bits);
        check("reverse frames", rev_n, 4);
        check("select in frame", rev_ss0, 1'b0);
        rev_ss_n <= 1'b1;
        repeat (400) @(posedge clock);
        check("select released", bc_frame.ss_n, 1'b1);
        $display("test reverse done");
        // Seventeen quick rises inside one slow frame overrun the buffer.
        reg_write(SIDEBAND_CTRL_OFFSET, 8'h00);
        reg_write(BC_CTRL_OFFSET, 8'h00);
        reg_write(SIDEBAND_CTRL_OFFSET, {5'h00, MODE_SPI_REVERSE});
        rev_ss_n <= 1'b0;
        repeat (34) begin
            repeat (4) @(posedge clock);
            rev_sclk <= ~rev_sclk;
        end
        repeat (4) @(posedge clock);
        expect_reg("status overflow", TUNNEL_STATUS_OFFSET, ST_OVF);
        reg_write(TUNNEL_STATUS_OFFSET, 8'(1 << STAT_OVF_BIT));
        expect_reg("status cleared", TUNNEL_STATUS_OFFSET, ST_CLR);
        $display("test overflow done");
        results();
    end
endmodule
`default_nettype wire
